// *** logic/tepc_cfg.svh ***
// Constants for the timer external pin control block.
// Assumes inclusion by bare name from the logic folder.
`ifndef TEPC_CFG_SVH
`define TEPC_CFG_SVH
`define TEPC_CNT_W     16
`define TEPC_SYNC_LEN  2
`define TEPC_CNT_RST   16'h0000
`define TEPC_CAP_RST   16'h0000
`define TEPC_CNT_MAX   16'hffff
`define TEPC_CLK_NS    20
`endif

// *** logic/tepc_pkg.sv ***
// Types for the timer external pin control block.
// Assumes the cfg header is compiled alongside.
package tepc_pkg;
    // Timer 2 operating modes
    typedef enum logic [1:0] {
        TEPC_T2_CAPTURE = 2'b00,
        TEPC_T2_RELOAD  = 2'b01,
        TEPC_T2_UPDOWN  = 2'b10,
        TEPC_T2_CLKOUT  = 2'b11
    } tepc_t2_mode_t;

    // Timer 0/1 control
    typedef struct packed {
        logic run;
        logic counter_mode;
    } tepc_t01_ctl_t;

    // Timer 2 control
    typedef struct packed {
        logic          run;
        logic          ext_clock;
        tepc_t2_mode_t mode;
    } tepc_t2_ctl_t;
endpackage : tepc_pkg

// *** logic/tepc_edge_sync.sv ***
// Two-flop pin synchroniser with falling-edge detector.
// Assumes the pin is asynchronous to the core clock.
`timescale 1ns/10ps
`include "tepc_cfg.svh"
module tepc_edge_sync (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      fall_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Reset to high matches the idle pulled-up pin
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    // R7 one event per edge
    assign fall_out  = prev_q & ~sync_q;

    // R7 single pulse check
    edge_one_pulse_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fall_out |=> !fall_out) else $error("Falling edge pulse lasted two cycles"); // R7
endmodule // tepc_edge_sync

// *** logic/tepc_timer_pins.sv ***
// Timer external pin control: timers 0/1 counting and timer 2 pin use.
// Assumes control comes from core logic on the same clock; pins are async.
// How it works
// R1 - In counter mode timer 0 and 1 counters step by one per count input falling edge.
// R2 - In capture mode timer 2 may count falling edges of its clock pin.
// R3 - In clock-out mode timer 2 drives its clock pin, toggling on overflow.
// R4 - Trigger falling edge in capture mode copies timer 2 count to capture.
// R5 - Trigger falling edge in auto-reload mode loads the reload value.
// R6 - In up-down mode trigger high counts up, low counts down.
// R7 - Every pin is synchronised, and falling edges found from successive samples.
`timescale 1ns/10ps
`include "tepc_cfg.svh"
module tepc_timer_pins #(
    parameter int CNT_W = `TEPC_CNT_W
) (
    input  wire logic                 CORE_CLK_IN,
    input  wire logic                 RST_N_IN,
    input  wire tepc_pkg::tepc_t01_ctl_t T0_CTL_IN,
    input  wire tepc_pkg::tepc_t01_ctl_t T1_CTL_IN,
    input  wire tepc_pkg::tepc_t2_ctl_t  T2_CTL_IN,
    input  wire logic [CNT_W-1:0]     T2_RELOAD_IN,
    input  wire logic [1:0]           TIMER01_COUNT_INPUT_IN,
    input  wire logic                 TIMER2_CLOCK_PIN_IN,
    input  wire logic                 TIMER2_EXTERNAL_TRIGGER_IN,
    output logic [CNT_W-1:0]          T0_COUNT_OUT,
    output logic [CNT_W-1:0]          T1_COUNT_OUT,
    output logic [CNT_W-1:0]          T2_COUNT_OUT,
    output logic [CNT_W-1:0]          T2_CAPTURE_OUT,
    output logic                      T2_CAPTURE_PULSE_OUT,
    output logic                      T2_OVERFLOW_OUT,
    output logic                      TIMER2_CLOCK_PIN_OUT,
    output logic                      TIMER2_CLOCK_PIN_OE_N_OUT
);
    logic [1:0]       t01_fall;
    logic             t2clk_fall;
    logic             trig_fall;
    logic             trig_lvl;
    logic [CNT_W-1:0] t0_q;
    logic [CNT_W-1:0] t1_q;
    logic [CNT_W-1:0] t2_q;
    logic [CNT_W-1:0] t2_d;
    logic [CNT_W-1:0] cap_q;
    logic             cap_pls_q;
    logic             ovf_q;
    logic             ovf_d;
    logic             clkout_q;
    logic             t2_tick;
    logic             count_up;
    logic             is_capture;
    logic             is_reload;
    logic             is_updown;
    logic             is_clkout;

    // Step a timer counter: external edge in counter mode, else core clock
    function automatic logic [CNT_W-1:0] step01(input logic [CNT_W-1:0] cur,
                                                input tepc_pkg::tepc_t01_ctl_t ctl,
                                                input logic fall);
        logic adv;
        adv = ctl.run & (ctl.counter_mode ? fall : 1'b1);
        return adv ? cur + {{(CNT_W-1){1'b0}}, 1'b1} : cur;
    endfunction

    // R7 sync count input pins
    for (genvar i = 0; i < 2; i++) begin : g_t01
        tepc_edge_sync u_sync (
            .clk_in    (CORE_CLK_IN),
            .rst_n_in  (RST_N_IN),
            .pin_in    (TIMER01_COUNT_INPUT_IN[i]),
            .level_out (),
            .fall_out  (t01_fall[i])
        );
    end

    // R7 sync timer 2 pins
    tepc_edge_sync u_t2clk (
        .clk_in    (CORE_CLK_IN),
        .rst_n_in  (RST_N_IN),
        .pin_in    (TIMER2_CLOCK_PIN_IN),
        .level_out (),
        .fall_out  (t2clk_fall)
    );
    tepc_edge_sync u_trig (
        .clk_in    (CORE_CLK_IN),
        .rst_n_in  (RST_N_IN),
        .pin_in    (TIMER2_EXTERNAL_TRIGGER_IN),
        .level_out (trig_lvl),
        .fall_out  (trig_fall)
    );

    // Mode decode
    assign is_capture = (T2_CTL_IN.mode == tepc_pkg::TEPC_T2_CAPTURE);
    assign is_reload  = (T2_CTL_IN.mode == tepc_pkg::TEPC_T2_RELOAD);
    assign is_updown  = (T2_CTL_IN.mode == tepc_pkg::TEPC_T2_UPDOWN);
    assign is_clkout  = (T2_CTL_IN.mode == tepc_pkg::TEPC_T2_CLKOUT);

    // R1 timer 0/1 counting
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            t0_q <= `TEPC_CNT_RST;
            t1_q <= `TEPC_CNT_RST;
        end else begin
            t0_q <= step01(t0_q, T0_CTL_IN, t01_fall[0]);
            t1_q <= step01(t1_q, T1_CTL_IN, t01_fall[1]);
        end
    end

    // R2 external clock only in capture mode; clock-out runs on core clock
    assign t2_tick  = T2_CTL_IN.run &
                      ((is_capture & T2_CTL_IN.ext_clock) ? t2clk_fall : 1'b1);
    // R6 direction from trigger level
    assign count_up = is_updown ? trig_lvl : 1'b1;

    // Timer 2 next value; reload edge has priority over a tick
    always_comb begin
        t2_d  = t2_q;
        ovf_d = 1'b0;
        // R5 reload on trigger edge
        if (is_reload && trig_fall) begin
            t2_d = T2_RELOAD_IN;
        end else if (t2_tick) begin
            if (count_up) begin
                if (t2_q == `TEPC_CNT_MAX) begin
                    ovf_d = 1'b1;
                    t2_d  = (is_capture) ? `TEPC_CNT_RST : T2_RELOAD_IN;
                end else begin
                    t2_d = t2_q + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end else begin
                // Down count underflows back to the max value
                if (t2_q == T2_RELOAD_IN) begin
                    ovf_d = 1'b1;
                    t2_d  = `TEPC_CNT_MAX;
                end else begin
                    t2_d = t2_q - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Timer 2 count and overflow
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            t2_q  <= `TEPC_CNT_RST;
            ovf_q <= 1'b0;
        end else begin
            t2_q  <= t2_d;
            ovf_q <= ovf_d;
        end
    end

    // R4 capture on trigger edge
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            cap_q     <= `TEPC_CAP_RST;
            cap_pls_q <= 1'b0;
        end else begin
            cap_pls_q <= is_capture & trig_fall;
            if (is_capture && trig_fall) begin
                cap_q <= t2_q;
            end
        end
    end

    // R3 clock-out toggles per overflow; pin released in other modes
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            clkout_q <= 1'b0;
        end else if (!is_clkout) begin
            clkout_q <= 1'b0;
        end else if (ovf_d) begin
            clkout_q <= ~clkout_q;
        end
    end

    assign T0_COUNT_OUT              = t0_q;
    assign T1_COUNT_OUT              = t1_q;
    assign T2_COUNT_OUT              = t2_q;
    assign T2_CAPTURE_OUT            = cap_q;
    assign T2_CAPTURE_PULSE_OUT      = cap_pls_q;
    assign T2_OVERFLOW_OUT           = ovf_q;
    assign TIMER2_CLOCK_PIN_OUT      = clkout_q;
    // R3 drive only in clock-out mode
    assign TIMER2_CLOCK_PIN_OE_N_OUT = ~is_clkout;

    // Assertions
    t0_edge_step_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (T0_CTL_IN.run && T0_CTL_IN.counter_mode && t01_fall[0])
        |=> t0_q == $past(t0_q) + 16'h0001) else $error("Timer 0 missed an edge"); // R1
    t1_hold_idle_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (T1_CTL_IN.counter_mode && !t01_fall[1])
        |=> t1_q == $past(t1_q)) else $error("Timer 1 counted without edge"); // R1
    t2_ext_hold_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (is_capture && T2_CTL_IN.ext_clock && !t2clk_fall && !trig_fall)
        |=> t2_q == $past(t2_q)) else $error("Timer 2 counted without pin edge"); // R2
    t2_ext_step_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (is_capture && T2_CTL_IN.run && T2_CTL_IN.ext_clock && t2clk_fall
         && t2_q != `TEPC_CNT_MAX)
        |=> t2_q == $past(t2_q) + 16'h0001) else $error("Timer 2 missed pin edge"); // R2
    clk_pin_toggle_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (is_clkout && ovf_d) |=> TIMER2_CLOCK_PIN_OUT != $past(TIMER2_CLOCK_PIN_OUT))
        else $error("Clock pin did not toggle"); // R3
    clk_pin_idle_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !is_clkout |=> !TIMER2_CLOCK_PIN_OUT) else $error("Clock pin not idle"); // R3
    cap_copy_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (is_capture && trig_fall) |=> (cap_q == $past(t2_q)) && cap_pls_q)
        else $error("Capture did not copy count"); // R4
    reload_load_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (is_reload && trig_fall) |=> t2_q == $past(T2_RELOAD_IN))
        else $error("Reload edge ignored"); // R5
    updown_dir_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (is_updown && T2_CTL_IN.run && !trig_lvl && t2_q != T2_RELOAD_IN)
        |=> t2_q == $past(t2_q) - 16'h0001) else $error("Down count wrong"); // R6
    updown_up_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        (is_updown && T2_CTL_IN.run && trig_lvl && t2_q != `TEPC_CNT_MAX)
        |=> t2_q == $past(t2_q) + 16'h0001) else $error("Up count wrong"); // R6
    trig_sync_a : assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        trig_fall |-> $past(trig_lvl) && !trig_lvl) else $error("Trigger edge bogus"); // R7

    cap_seen_c    : cover property (@(posedge CORE_CLK_IN) is_capture && trig_fall);
    reload_seen_c : cover property (@(posedge CORE_CLK_IN) is_reload && trig_fall);
    down_seen_c   : cover property (@(posedge CORE_CLK_IN) is_updown && !trig_lvl);
    clkout_seen_c : cover property (@(posedge CORE_CLK_IN) is_clkout && ovf_d);
endmodule // tepc_timer_pins

// *** tb/tepc_pin_source.sv ***
// Pin source model: outside circuit driving the timer input pins.
// Assumes the pins idle high through the port pullups.
`timescale 1ns/10ps
module tepc_pin_source (
    input  wire logic       clk_in,
    output logic [1:0]      cnt_pin_out,
    output logic            clk_pin_out,
    output logic            trig_pin_out
);
    // Idle high, as the pullups hold the lines
    initial begin
        cnt_pin_out  = 2'h3;
        clk_pin_out  = 1'h1;
        trig_pin_out = 1'h1;
    end

    // Select 0/1 count pins, 2 clock pin, 3 trigger
    task automatic set_pin(input int sel, input logic lvl);
        if (sel < 2) cnt_pin_out[sel] <= lvl;
        else if (sel == 2) clk_pin_out <= lvl;
        else trig_pin_out <= lvl;
    endtask

    // Three cycles a level, well above what the synchroniser can lose
    task automatic pulse(input int sel, input int n);
        @(posedge clk_in);
        for (int k = 0; k < n; k++) begin
            set_pin(sel, 1'h0);
            repeat (3) @(posedge clk_in);
            set_pin(sel, 1'h1);
            repeat (3) @(posedge clk_in);
        end
    endtask
endmodule // tepc_pin_source

// *** tb/tepc_timer_pins_bench.sv ***
// Bench for the timer pin block: pin source model plus scenario tasks.
// Assumes a 50 MHz core clock and synchronous active-low reset.
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin \
    failures++; $display("BAD %0t %s", $time, msg); end end
module tepc_timer_pins_bench;
    logic                  core_clk = 1'h0;
    logic                  rst_n    = 1'h0;
    tepc_pkg::tepc_t01_ctl_t t0_ctl = '0;
    tepc_pkg::tepc_t01_ctl_t t1_ctl = '0;
    tepc_pkg::tepc_t2_ctl_t  t2_ctl = '0;
    logic [15:0]           reload   = 16'h0000;
    logic [1:0]            cnt_pin;
    logic                  clk_pin, trig_pin, pin_out, oe_n, cap_pulse, ovf;
    logic [15:0]           t0_cnt, t1_cnt, t2_cnt, cap, c1;
    int                    failures = 0;
    int                    samples_checked = 0;
    int                    cap_seen = 0;

    tepc_timer_pins i_tepc_timer_pins (.CORE_CLK_IN(core_clk), .RST_N_IN(rst_n),
        .T0_CTL_IN(t0_ctl), .T1_CTL_IN(t1_ctl), .T2_CTL_IN(t2_ctl), .T2_RELOAD_IN(reload),
        .TIMER01_COUNT_INPUT_IN(cnt_pin), .TIMER2_CLOCK_PIN_IN(clk_pin),
        .TIMER2_EXTERNAL_TRIGGER_IN(trig_pin), .T0_COUNT_OUT(t0_cnt), .T1_COUNT_OUT(t1_cnt),
        .T2_COUNT_OUT(t2_cnt), .T2_CAPTURE_OUT(cap), .T2_CAPTURE_PULSE_OUT(cap_pulse),
        .T2_OVERFLOW_OUT(ovf), .TIMER2_CLOCK_PIN_OUT(pin_out),
        .TIMER2_CLOCK_PIN_OE_N_OUT(oe_n));
    tepc_pin_source i_tepc_pin_source (.clk_in(core_clk), .cnt_pin_out(cnt_pin),
        .clk_pin_out(clk_pin), .trig_pin_out(trig_pin));

    // 20 ns clock
    initial forever #10 core_clk = ~core_clk;
    // Capture pulses are counted so a doubled event shows up
    always @(posedge core_clk) if (rst_n && cap_pulse === 1'h1) cap_seen++;

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic end_of_test();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t01_count();
        @(posedge core_clk);
        t0_ctl <= '{run: 1'h1, counter_mode: 1'h1};
        t1_ctl <= '{run: 1'h1, counter_mode: 1'h1};
        i_tepc_pin_source.pulse(0, 3);
        i_tepc_pin_source.pulse(1, 5);
        step(6);
        `CHK(t0_cnt, 16'h0003, "timer0 count")
        `CHK(t1_cnt, 16'h0005, "timer1 count")
        @(posedge core_clk);
        t0_ctl <= '{run: 1'h1, counter_mode: 1'h0};
        step(2);
        c1 = t0_cnt;
        step(10);
        `CHK(t0_cnt - c1, 16'h000a, "timer0 core clock count")
    endtask

    task automatic t2_capture();
        @(posedge core_clk);
        t2_ctl <= '{1'h1, 1'h1, tepc_pkg::TEPC_T2_CAPTURE};
        i_tepc_pin_source.pulse(2, 4);
        step(6);
        `CHK(t2_cnt, 16'h0004, "timer2 external clock count")
        `CHK(oe_n, 1'h1, "clock pin driven outside clock-out")
        i_tepc_pin_source.pulse(3, 1);
        step(6);
        `CHK(cap, 16'h0004, "capture value")
        `CHK(cap_seen, 1, "one capture per trigger fall")
    endtask

    task automatic t2_reload(input logic [15:0] val);
        @(posedge core_clk);
        reload <= val;
        t2_ctl <= '{1'h1, 1'h0, tepc_pkg::TEPC_T2_RELOAD};
        i_tepc_pin_source.pulse(3, 1);
        step(2);
        `CHK(t2_cnt - val < 16'h0010, 1'h1, "reload from trigger")
    endtask

    task automatic t2_updown();
        @(posedge core_clk);
        reload <= 16'h0000;
        t2_ctl <= '{1'h1, 1'h0, tepc_pkg::TEPC_T2_UPDOWN};
        step(2);
        c1 = t2_cnt;
        step(10);
        `CHK(t2_cnt - c1, 16'h000a, "up count with trigger high")
        i_tepc_pin_source.set_pin(3, 1'h0);
        step(6);
        c1 = t2_cnt;
        step(10);
        `CHK(c1 - t2_cnt, 16'h000a, "down count with trigger low")
        i_tepc_pin_source.set_pin(3, 1'h1);
        step(6);
    endtask

    // clock pin driven and toggling in clock-out
    task automatic t2_clkout();
        logic lvl;
        t2_reload(16'hfff0);
        @(posedge core_clk);
        t2_ctl <= '{1'h1, 1'h0, tepc_pkg::TEPC_T2_CLKOUT};
        step(1);
        `CHK(oe_n, 1'h0, "clock pin driven in clock-out")
        lvl = pin_out;
        for (int k = 0; k < 24 && pin_out === lvl; k++) step(1);
        `CHK(pin_out, ~lvl, "clock pin toggles on overflow")
        `CHK(ovf, 1'h1, "overflow pulse with toggle")
        @(posedge core_clk);
        t2_ctl <= '{1'h0, 1'h0, tepc_pkg::TEPC_T2_CAPTURE};
        step(1);
        `CHK(oe_n, 1'h1, "clock pin released")
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        step(2);
        t01_count();
        t2_capture();
        t2_reload(16'h8000);
        t2_updown();
        t2_clkout();
        end_of_test();
    end
endmodule // tepc_timer_pins_bench
